// ==== rtl/sstf_consts.svh ====
`ifndef SSTF_CONSTS_SVH
`define SSTF_CONSTS_SVH

// Field lengths in byte times
`define SSTF_DATA_LEN 9'd256
`define SSTF_OVERHEAD_LEN 9'd59
`define SSTF_GAP1_LEN 9'd16
`define SSTF_SYNC_LEN 9'd13
`define SSTF_ID_LEN 9'd3
`define SSTF_CRC_LEN 9'd2
`define SSTF_PAD_LEN 9'd3
`define SSTF_GAP2_LEN 9'd3
`define SSTF_GAP3_LEN 9'd15

// Byte values
`define SSTF_ID_MARK 8'hfe
`define SSTF_DATA_MARK 8'hfb
`define SSTF_GAP_FILL 8'h4e
`define SSTF_SYNC_BYTE 8'h00

// Check code
`define SSTF_CRC_INIT 16'hffff
`define SSTF_CRC_POLY 16'h1021

// Data buffer shape
`define SSTF_FIFO_WIDTH 8
`define SSTF_FIFO_DEPTH 16

`endif

// ==== rtl/sstf_fifo.sv ====
`timescale 1ns/10ps
`include "sstf_consts.svh"

module sstf_fifo #(
    parameter int WIDTH = `SSTF_FIFO_WIDTH,
    parameter int DEPTH = `SSTF_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    // Full and empty come straight from the fill count
    assign in_ready = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_r[rd_ptr_r];

    // Storage has no reset; only the pointers and fill count need one
    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clock) begin
        if (reset) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 :
                            wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 :
                            rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule

// ==== rtl/sstf_formatter.sv ====
`timescale 1ns/10ps
`include "sstf_consts.svh"

module sstf_formatter (
    input wire logic clock,
    input wire logic reset,
    input wire logic format_en,
    input wire logic [7:0] cylinder,
    input wire logic [7:0] head,
    input wire logic [7:0] sectors_per_track,
    input wire sstf_pkg::sstf_byte_t host_data,
    input wire logic host_valid,
    output logic host_ready,
    input wire logic index_pin,
    output sstf_pkg::sstf_byte_t wr_byte,
    output logic wr_mark,
    output logic wr_gate,
    output logic underrun,
    output logic track_short,
    input wire sstf_pkg::sstf_byte_t rd_byte_pin,
    input wire logic rd_valid_pin,
    input wire logic rd_mark_pin,
    output sstf_pkg::sstf_byte_t rd_data,
    output logic rd_data_valid,
    output logic id_ok,
    output logic id_err,
    output logic data_ok,
    output logic data_err
);
    import sstf_pkg::*;

    // One step of CCITT CRC-16, MSB first, shared by writer and checker
    function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                             input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            c = c[15] ? ((c << 1) ^ `SSTF_CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    // Pin synchronisers, two flops each
    logic index_s1_r;
    logic index_s2_r;
    logic index_d_r;
    sstf_byte_t rd_byte_s1_r;
    sstf_byte_t rd_byte_s2_r;
    logic rd_valid_s1_r;
    logic rd_valid_s2_r;
    logic rd_mark_s1_r;
    logic rd_mark_s2_r;
    logic index_rise;

    always_ff @(posedge clock) begin
        if (reset) begin
            index_s1_r <= 1'b0;
            index_s2_r <= 1'b0;
            index_d_r <= 1'b0;
            rd_byte_s1_r <= 8'h00;
            rd_byte_s2_r <= 8'h00;
            rd_valid_s1_r <= 1'b0;
            rd_valid_s2_r <= 1'b0;
            rd_mark_s1_r <= 1'b0;
            rd_mark_s2_r <= 1'b0;
        end else begin
            index_s1_r <= index_pin;
            index_s2_r <= index_s1_r;
            index_d_r <= index_s2_r;
            rd_byte_s1_r <= rd_byte_pin;
            rd_byte_s2_r <= rd_byte_s1_r;
            rd_valid_s1_r <= rd_valid_pin;
            rd_valid_s2_r <= rd_valid_s1_r;
            rd_mark_s1_r <= rd_mark_pin;
            rd_mark_s2_r <= rd_mark_s1_r;
        end
    end

    assign index_rise = index_s2_r && !index_d_r;

    // Host data is buffered so short host stalls do not starve a sector
    sstf_byte_t fifo_data;
    logic fifo_valid;
    logic fifo_pop;

    sstf_fifo #(
        .WIDTH(`SSTF_FIFO_WIDTH),
        .DEPTH(`SSTF_FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .reset(reset),
        .in_data(host_data),
        .in_valid(host_valid),
        .in_ready(host_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // Write sequencer registers
    sstf_wstate_e state_r;
    sstf_wstate_e state_nxt;
    logic [8:0] cnt_r;
    logic [8:0] cnt_nxt;
    logic [7:0] sector_r;
    logic [15:0] crc_r;
    sstf_byte_t byte_nxt;
    logic mark_nxt;
    logic last_sector;

    assign last_sector = (sector_r + 8'h01 >= sectors_per_track);
    assign fifo_pop = (state_r == SSTF_DATA);

    // Next state, byte to send and field counter
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + 9'd1;
        byte_nxt = `SSTF_GAP_FILL;
        mark_nxt = 1'b0;
        case (state_r)
            SSTF_GAP1: begin
                if (cnt_r == `SSTF_GAP1_LEN - 9'd1) begin
                    state_nxt = SSTF_SYNC1;
                    cnt_nxt = 9'd0;
                end
            end
            SSTF_SYNC1: begin
                byte_nxt = `SSTF_SYNC_BYTE;
                if (cnt_r == `SSTF_SYNC_LEN - 9'd1) begin
                    state_nxt = SSTF_IDAM;
                end
            end
            SSTF_IDAM: begin
                byte_nxt = `SSTF_ID_MARK;
                mark_nxt = 1'b1;
                state_nxt = SSTF_IDF;
                cnt_nxt = 9'd0;
            end
            SSTF_IDF: begin
                byte_nxt = (cnt_r == 9'd0) ? cylinder :
                           (cnt_r == 9'd1) ? head : sector_r;
                if (cnt_r == `SSTF_ID_LEN - 9'd1) begin
                    state_nxt = SSTF_IDCRC;
                    cnt_nxt = 9'd0;
                end
            end
            // check bytes of either field, high byte first
            SSTF_IDCRC, SSTF_DCRC: begin
                byte_nxt = (cnt_r == 9'd0) ? crc_r[15:8] : crc_r[7:0];
                if (cnt_r == `SSTF_CRC_LEN - 9'd1) begin
                    state_nxt = (state_r == SSTF_IDCRC) ? SSTF_IDPAD :
                                SSTF_DPAD;
                    cnt_nxt = 9'd0;
                end
            end
            // three trailing zeros after either field
            SSTF_IDPAD, SSTF_DPAD: begin
                byte_nxt = `SSTF_SYNC_BYTE;
                if (cnt_r == `SSTF_PAD_LEN - 9'd1) begin
                    state_nxt = (state_r == SSTF_IDPAD) ? SSTF_GAP2 :
                                SSTF_GAP3;
                    cnt_nxt = 9'd0;
                end
            end
            SSTF_GAP2: begin
                if (cnt_r == `SSTF_GAP2_LEN - 9'd1) begin
                    state_nxt = SSTF_SYNC2;
                    cnt_nxt = 9'd0;
                end
            end
            SSTF_SYNC2: begin
                byte_nxt = `SSTF_SYNC_BYTE;
                if (cnt_r == `SSTF_SYNC_LEN - 9'd1) begin
                    state_nxt = SSTF_DAM;
                end
            end
            SSTF_DAM: begin
                byte_nxt = `SSTF_DATA_MARK;
                mark_nxt = 1'b1;
                state_nxt = SSTF_DATA;
                cnt_nxt = 9'd0;
            end
            // data bytes; an empty buffer sends zero to keep timing
            SSTF_DATA: begin
                byte_nxt = fifo_valid ? fifo_data : 8'h00;
                if (cnt_r == `SSTF_DATA_LEN - 9'd1) begin
                    state_nxt = SSTF_DCRC;
                    cnt_nxt = 9'd0;
                end
            end
            // inter-sector gap, then next sector or closing gap
            SSTF_GAP3: begin
                if (cnt_r == `SSTF_GAP3_LEN - 9'd1) begin
                    state_nxt = last_sector ? SSTF_GAP4 : SSTF_SYNC1;
                    cnt_nxt = 9'd0;
                end
            end
            // closing gap, like idle, holds until the index
            SSTF_IDLE, SSTF_GAP4: begin
                cnt_nxt = 9'd0;
            end
            default: begin
                state_nxt = SSTF_IDLE;
            end
        endcase
        // an index starts a fresh track at the opening gap, or idles when format_en is low
        if (index_rise) begin
            state_nxt = format_en ? SSTF_GAP1 : SSTF_IDLE;
            cnt_nxt = 9'd0;
        end
    end

    // Sequencer state and counter
    always_ff @(posedge clock) begin
        if (reset) begin
            state_r <= SSTF_IDLE;
            cnt_r <= 9'd0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // sector numbers restart at zero each revolution
    always_ff @(posedge clock) begin
        if (reset || index_rise) begin
            sector_r <= 8'h00;
        end else if (state_r == SSTF_GAP3 && state_nxt != SSTF_GAP3) begin
            sector_r <= sector_r + 8'h01;
        end
    end

    // running check, seeded by each address mark
    always_ff @(posedge clock) begin
        if (reset) begin
            crc_r <= `SSTF_CRC_INIT;
        end else if (state_r == SSTF_IDAM || state_r == SSTF_DAM) begin
            crc_r <= crc_step(`SSTF_CRC_INIT, byte_nxt);
        end else if (state_r == SSTF_IDF || state_r == SSTF_DATA) begin
            crc_r <= crc_step(crc_r, byte_nxt);
        end
    end

    // Registered write stream toward the drive
    always_ff @(posedge clock) begin
        if (reset) begin
            wr_byte <= 8'h00;
            wr_mark <= 1'b0;
            wr_gate <= 1'b0;
            underrun <= 1'b0;
            track_short <= 1'b0;
        end else begin
            wr_byte <= byte_nxt;
            wr_mark <= mark_nxt;
            wr_gate <= (state_r != SSTF_IDLE);
            underrun <= (state_r == SSTF_DATA) && !fifo_valid;
            // Index came before the last sector was finished
            track_short <= index_rise && state_r != SSTF_IDLE &&
                           state_r != SSTF_GAP4;
        end
    end

    // Read checker: counts field bytes after each detected id or data mark
    logic rd_active_r;
    logic rd_is_data_r;
    logic [8:0] rd_left_r;
    logic [15:0] rd_crc_r;
    logic [15:0] rd_crc_nxt;
    logic rd_take;
    logic rd_end;

    assign rd_take = rd_valid_s2_r && !rd_mark_s2_r && rd_active_r;
    assign rd_crc_nxt = crc_step(rd_crc_r, rd_byte_s2_r);
    assign rd_end = rd_take && (rd_left_r == 9'd1);

    // field tracking; a mark restarts the check
    always_ff @(posedge clock) begin
        if (reset) begin
            rd_active_r <= 1'b0;
            rd_is_data_r <= 1'b0;
            rd_left_r <= 9'd0;
            rd_crc_r <= `SSTF_CRC_INIT;
        end else if (rd_valid_s2_r && rd_mark_s2_r) begin
            rd_is_data_r <= (rd_byte_s2_r == `SSTF_DATA_MARK);
            rd_active_r <= (rd_byte_s2_r == `SSTF_DATA_MARK) ||
                           (rd_byte_s2_r == `SSTF_ID_MARK);
            rd_left_r <= (rd_byte_s2_r == `SSTF_DATA_MARK) ?
                         `SSTF_DATA_LEN + `SSTF_CRC_LEN :
                         `SSTF_ID_LEN + `SSTF_CRC_LEN;
            rd_crc_r <= crc_step(`SSTF_CRC_INIT, rd_byte_s2_r);
        end else if (rd_take) begin
            rd_crc_r <= rd_crc_nxt;
            rd_left_r <= rd_left_r - 9'd1;
            rd_active_r <= !rd_end;
        end
    end

    // check bytes included leave a zero remainder when intact
    always_ff @(posedge clock) begin
        if (reset) begin
            id_ok <= 1'b0;
            id_err <= 1'b0;
            data_ok <= 1'b0;
            data_err <= 1'b0;
            rd_data <= 8'h00;
            rd_data_valid <= 1'b0;
        end else begin
            id_ok <= rd_end && !rd_is_data_r && rd_crc_nxt == 16'h0000;
            id_err <= rd_end && !rd_is_data_r && rd_crc_nxt != 16'h0000;
            data_ok <= rd_end && rd_is_data_r && rd_crc_nxt == 16'h0000;
            data_err <= rd_end && rd_is_data_r && rd_crc_nxt != 16'h0000;
            rd_data <= rd_byte_s2_r;
            rd_data_valid <= rd_take && rd_is_data_r &&
                             rd_left_r > `SSTF_CRC_LEN;
        end
    end

endmodule

// ==== rtl/sstf_pkg.sv ====
package sstf_pkg;

    typedef logic [7:0] sstf_byte_t;

    // Write sequencer states
    typedef enum logic [3:0] {
        SSTF_IDLE,
        SSTF_GAP1,
        SSTF_SYNC1,
        SSTF_IDAM,
        SSTF_IDF,
        SSTF_IDCRC,
        SSTF_IDPAD,
        SSTF_GAP2,
        SSTF_SYNC2,
        SSTF_DAM,
        SSTF_DATA,
        SSTF_DCRC,
        SSTF_DPAD,
        SSTF_GAP3,
        SSTF_GAP4
    } sstf_wstate_e;

endpackage

// ==== sim/sstf_chk.sv ====
`timescale 1ns/10ps
module sstf_chk (
    input wire logic clock,
    input wire logic reset,
    input wire sstf_pkg::sstf_byte_t wr_byte,
    input wire logic wr_mark,
    input wire logic wr_gate,
    input wire logic data_ok,
    input wire logic data_err
);
    import sstf_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Mark strobes by kind
    wire logic id_m = wr_mark && wr_byte == 8'hfe;
    wire logic dat_m = wr_mark && wr_byte == 8'hfb;
    sequence s_pad3; (wr_byte == 8'h00)[*3]; endsequence
    sequence s_gap3; (wr_byte == 8'h4e)[*3]; endsequence
    property p_mark_gate; wr_mark |-> wr_gate && (id_m || dat_m); endproperty
    property p_gap1;
        $rose(wr_gate) |-> (wr_byte == 8'h4e)[*8] ##1 s_gap3;
    endproperty
    property p_id_sync;
        id_m |-> $past(wr_byte) == 8'h00 && $past(wr_byte, 13) == 8'h00
            && $past(wr_byte, 14) == 8'h4e;
    endproperty
    property p_id_tail;
        id_m |-> ##6 s_pad3 ##1 s_gap3 ##1 (wr_byte == 8'h00)[*8];
    endproperty
    property p_dat_sync;
        dat_m |-> $past(wr_byte, 13) == 8'h00 && $past(wr_byte, 14) == 8'h4e
            && $past(wr_byte, 17) == 8'h00;
    endproperty
    property p_dat_tail;
        dat_m |-> ##259 s_pad3 ##1 (wr_byte == 8'h4e)[*8];
    endproperty
    // Cycles since the last id mark; a counter replaces a too-long delay
    logic [9:0] since_id_r;
    always_ff @(posedge clock) begin
        if (reset) begin
            since_id_r <= 10'h000;
        end else if (id_m) begin
            since_id_r <= 10'h001;
        end else if (since_id_r != 10'h000 && since_id_r != 10'h3ff) begin
            since_id_r <= since_id_r + 10'h001;
        end
    end
    // One sector length after a mark: next mark or closing gap
    property p_sect_len;
        since_id_r == 10'h13b |-> id_m || wr_byte == 8'h4e;
    endproperty
    property p_chk_once;
        (data_ok || data_err) |=> (!(data_ok || data_err))[*8];
    endproperty
    a_mark_gate: assert property (p_mark_gate)
        else $error("mark byte out of place");
    a_gap1: assert property (p_gap1)
        else $error("opening gap too short");
    a_id_sync: assert property (p_id_sync)
        else $error("id mark without sync zeros");
    a_id_tail: assert property (p_id_tail)
        else $error("id field tail wrong");
    a_dat_sync: assert property (p_dat_sync)
        else $error("data mark without tolerance gap");
    a_dat_tail: assert property (p_dat_tail)
        else $error("data field tail or gap wrong");
    a_sect_len: assert property (p_sect_len)
        else $error("sector length wrong");
    a_chk_once: assert property (p_chk_once)
        else $error("field check pulse repeated");
endmodule

// ==== sim/sstf_drive.sv ====
`timescale 1ns/10ps
module sstf_drive (
    input wire logic clock,
    input wire logic reset,
    input wire logic [15:0] period,
    input wire logic corrupt,
    input wire sstf_pkg::sstf_byte_t wr_byte,
    input wire logic wr_mark,
    input wire logic wr_gate,
    output logic index_pin,
    output sstf_pkg::sstf_byte_t rd_byte_pin,
    output logic rd_valid_pin,
    output logic rd_mark_pin
);
    import sstf_pkg::*;
    logic [15:0] rev_r;
    always_ff @(posedge clock) begin
        if (reset || rev_r >= period - 16'h0001) rev_r <= 16'h0000;
        else rev_r <= rev_r + 16'h0001;
    end
    assign index_pin = !reset && rev_r < 16'h0004;
    // head reads back what was written, one byte flipped on request
    always_ff @(posedge clock) begin
        rd_valid_pin <= wr_gate && !reset;
        rd_mark_pin <= wr_gate && wr_mark;
        if (reset) rd_byte_pin <= 8'h00;
        else if (wr_gate) rd_byte_pin <= wr_byte ^
            {7'h00, corrupt && rev_r == 16'h00c8};
        else rd_byte_pin <= ~rd_byte_pin; // Idle line inverts its last byte every cycle
    end
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/10ps
module testbench;
    import sstf_pkg::*;
    logic clock, reset, format_en, host_valid, host_ready, index_pin;
    logic wr_mark, wr_gate, underrun, track_short, rd_valid_pin, rd_mark_pin;
    logic rd_data_valid, id_ok, id_err, data_ok, data_err, corrupt, idx_q;
    logic [7:0] cylinder, head, spt;
    logic [15:0] period, run_crc;
    sstf_byte_t host_data, wr_byte, rd_byte_pin, rd_data;
    logic [8:0] cap [0:799];
    logic [8:0] q [$];
    int fail_count, checks, cycles, sent, ncap, n_idx, n_short, n_und;
    int n_idok, n_iderr, n_dok, n_derr, n_rdv, n_rdnz;
    sstf_formatter u_dut (.clock(clock), .reset(reset), .format_en(format_en),
        .cylinder(cylinder), .head(head), .sectors_per_track(spt),
        .host_data(host_data), .host_valid(host_valid),
        .host_ready(host_ready), .index_pin(index_pin), .wr_byte(wr_byte),
        .wr_mark(wr_mark), .wr_gate(wr_gate), .underrun(underrun),
        .track_short(track_short), .rd_byte_pin(rd_byte_pin),
        .rd_valid_pin(rd_valid_pin), .rd_mark_pin(rd_mark_pin),
        .rd_data(rd_data), .rd_data_valid(rd_data_valid), .id_ok(id_ok),
        .id_err(id_err), .data_ok(data_ok), .data_err(data_err));
    sstf_drive u_drive (.clock(clock), .reset(reset), .period(period),
        .corrupt(corrupt), .wr_byte(wr_byte), .wr_mark(wr_mark),
        .wr_gate(wr_gate), .index_pin(index_pin), .rd_byte_pin(rd_byte_pin),
        .rd_valid_pin(rd_valid_pin), .rd_mark_pin(rd_mark_pin));
    // Byte clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Tallies and capture on the sampling edge; a hang ends as a failure
    always @(posedge clock) begin
        cycles++;
        if (host_valid && host_ready) sent++;
        if (index_pin && !idx_q) n_idx++;
        idx_q = index_pin;
        n_short += track_short;
        n_und += underrun;
        n_idok += id_ok;
        n_iderr += id_err;
        n_dok += data_ok;
        n_derr += data_err;
        // Read-back bytes; an unknown counts as nonzero
        if (rd_data_valid) begin
            n_rdv++;
            if (rd_data !== 8'h00) n_rdnz++;
        end
        if (wr_gate && ncap < 800) begin
            cap[ncap] = {wr_mark, wr_byte};
            ncap++;
        end
        if (cycles == 10000) begin
            fail_count++;
            $display("ERROR %0t: timeout", $time);
            tally_and_finish();
        end
    end
    // Host bytes count up so their order is visible
    always @(negedge clock) host_data <= sent[7:0];
    task automatic tally_and_finish();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk_b(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int exp);
        checks++;
        if (got != exp) begin
            fail_count++;
            $display("ERROR %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] crc8(input logic [15:0] c,
                                         input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction
    task automatic put(input logic [8:0] v, input int n);
        repeat (n) q.push_back(v);
    endtask
    task automatic emit(input logic [7:0] b);
        run_crc = crc8(run_crc, b);
        put({1'b0, b}, 1);
    endtask
    task automatic mark(input logic [7:0] b);
        run_crc = crc8(16'hffff, b);
        put({1'b1, b}, 1);
    endtask
    task automatic crc_out();
        put({1'b0, run_crc[15:8]}, 1);
        put({1'b0, run_crc[7:0]}, 1);
    endtask
    // Clears field tallies at one index and returns at the next
    task automatic track_window();
        @(posedge index_pin);
        @(negedge clock);
        n_und = 0;
        n_idok = 0;
        n_iderr = 0;
        n_dok = 0;
        n_derr = 0;
        n_rdv = 0;
        n_rdnz = 0;
        @(posedge index_pin);
        @(negedge clock);
    endtask
    // Early indexes restart the track and are flagged
    task automatic t_short();
        @(posedge index_pin);
        repeat (6) @(negedge clock);
        n_short = 0;
        n_idx = 0;
        format_en = 1'b1;
        wait (n_idx == 5);
        @(negedge clock);
        period = 16'h02bc;
        repeat (8) @(negedge clock);
        chk_n(n_short, 4);
    endtask
    // Starved host: zeros written, fields still check clean
    task automatic t_under();
        track_window();
        chk_n(n_und, 512);
        chk_n(n_idok, 2);
        chk_n(n_dok, 2);
        chk_n(n_iderr + n_derr, 0);
        chk_n(n_rdv, 512);
        chk_n(n_rdnz, 0);
    endtask
    // Whole track compared byte for byte against the layout
    task automatic t_track();
        int k;
        @(posedge index_pin);
        @(negedge clock);
        sent = 0;
        ncap = 0;
        host_valid = 1'b1;
        q = {};
        put(9'h04e, 16);
        for (int s = 0; s < 2; s++) begin
            put(9'h000, 13);
            mark(8'hfe);
            emit(cylinder);
            emit(head);
            emit(8'(s));
            crc_out();
            put(9'h000, 3);
            put(9'h04e, 3);
            put(9'h000, 13);
            mark(8'hfb);
            for (int i = 0; i < 256; i++) emit(8'(i));
            crc_out();
            put(9'h000, 3);
            put(9'h04e, 15);
        end
        put(9'h04e, 700 - 646 + 16);
        put(9'h000, 13);
        mark(8'hfe);
        wait (ncap == 800);
        @(negedge clock);
        host_valid = 1'b0;
        k = 0;
        while (k < 799 && cap[k] !== 9'h1fe) k++;
        for (int i = 0; i < q.size(); i++) begin
            chk_b(cap[k - 29 + i], q[i]);
            if (cap[k - 29 + i] !== q[i]) break;
        end
    endtask
    // One flipped data byte on read gives a data error only
    task automatic t_corrupt();
        corrupt = 1'b1;
        track_window();
        corrupt = 1'b0;
        chk_n(n_idok, 2);
        chk_n(n_dok, 1);
        chk_n(n_derr, 1);
        chk_n(n_rdv, 512);
        chk_n(n_rdnz, 1);
    endtask
    // Enable dropped: gate held through the closing gap, low after index
    task automatic t_stop();
        chk_b({8'h00, wr_gate}, 9'h001);
        format_en = 1'b0;
        @(posedge index_pin);
        repeat (6) @(negedge clock);
        chk_b({8'h00, wr_gate}, 9'h000);
        chk_n(n_short, 4);
    endtask
    // Main sequence
    initial begin
        reset = 1'b1;
        format_en = 1'b0;
        host_valid = 1'b0;
        cylinder = 8'h5a;
        head = 8'h03;
        spt = 8'h02;
        period = 16'h000c;
        corrupt = 1'b0;
        ncap = 800;
        idx_q = 1'b0;
        repeat (4) @(negedge clock);
        reset = 1'b0;
        t_short();
        t_under();
        t_track();
        t_corrupt();
        t_stop();
        tally_and_finish();
    end
endmodule
bind sstf_formatter sstf_chk u_chk (.clock(clock), .reset(reset),
    .wr_byte(wr_byte), .wr_mark(wr_mark), .wr_gate(wr_gate),
    .data_ok(data_ok), .data_err(data_err));
